/* File: design/cssi_pkg.sv */
// cssi_pkg: constants and types of the core status, stack and interrupt block
// assumes a single core clock and register access over APB
package cssi_pkg;
	localparam int              NSRC          = 4;
	localparam int              SRC_W         = 2;
	localparam logic [NSRC-1:0] SRC_IS_LEVEL  = 4'h8;
	localparam int              NREGS         = 32;
	localparam int              SRAM_WORDS    = 128;
	localparam logic [7:0]      ADDR_STATUS   = 8'h00;
	localparam logic [7:0]      ADDR_SPL      = 8'h04;
	localparam logic [7:0]      ADDR_SPH      = 8'h08;
	localparam logic [7:0]      ADDR_IEN      = 8'h0C;
	localparam logic [7:0]      ADDR_IFLG     = 8'h10;
	localparam logic [7:0]      ADDR_PC       = 8'h14;
	localparam int              BIT_I         = 7;
	localparam int              BIT_T         = 6;
	localparam int              BIT_H         = 5;
	localparam int              BIT_S         = 4;
	localparam int              BIT_V         = 3;
	localparam int              BIT_N         = 2;
	localparam int              BIT_Z         = 1;
	localparam int              BIT_C         = 0;
	localparam logic [7:0]      STATUS_RST    = 8'h00;
	localparam logic [7:0]      SP_RST        = 8'h00;
	localparam logic [9:0]      PC_RST        = 10'h000;
	localparam logic [15:0]     REG_SPACE_END = 16'h0020;
	localparam logic [15:0]     SRAM_BASE     = 16'h0060;
	localparam logic [15:0]     SRAM_END      = 16'h00E0;
	localparam logic [3:0]      PAIR_W        = 4'hC;
	localparam logic [3:0]      PAIR_X        = 4'hD;
	localparam logic [1:0]      STK_LAST      = 2'h1;
	localparam logic [1:0]      RET_LAST      = 2'h2;
	localparam logic [1:0]      ENTRY_LAST    = 2'h3;

	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_EOR, OP_MOV, OP_LDI, OP_ADIW,
		OP_BST, OP_BLD, OP_SEI, OP_CLI, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTR,
		OP_LD, OP_ST
	} cssi_op_t;

	typedef enum logic [1:0] {PM_PLAIN, PM_POSTINC, PM_PREDEC, PM_DISP} cssi_pmode_t;

	typedef enum logic [1:0] {ST_IDLE, ST_CALL, ST_INT, ST_RET} cssi_state_t;
endpackage

/* File: design/cssi_regfile.sv */
// cssi_regfile: 32 working registers with 8-bit and 16-bit pair ports
// assumes the core never writes the same register through both ports at once
`timescale 1ns/1ns
module cssi_regfile
	import cssi_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic [4:0]  ra_addr,
	output wire logic [7:0]  ra_data,
	input  wire logic [4:0]  rb_addr,
	output wire logic [7:0]  rb_data,
	input  wire logic [3:0]  pr_sel,
	output wire logic [15:0] pr_data,
	input  wire logic        we8,
	input  wire logic [4:0]  wa,
	input  wire logic [7:0]  wd,
	input  wire logic        we16,
	input  wire logic [3:0]  wpair,
	input  wire logic [15:0] wd16
);
	logic [7:0] rf [NREGS];

	assign ra_data = rf[ra_addr];
	assign rb_data = rf[rb_addr];
	assign pr_data = {rf[{pr_sel, 1'b1}], rf[{pr_sel, 1'b0}]};

	// byte write wins over the pair write on overlap
	for (genvar i = 0; i < NREGS; i++) begin : g_reg
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rf[i] <= 8'h00;
			end else if (ce) begin
				if (we8 && wa == 5'(i)) begin
					rf[i] <= wd;
				end else if (we16 && wpair == 4'(i / 2)) begin
					rf[i] <= (i % 2 == 1) ? wd16[15:8] : wd16[7:0];
				end
			end
		end
	end
endmodule

/* File: design/cssi_irq_arb.sv */
// cssi_irq_arb: pending flags of the interrupt sources and the priority pick
// assumes src_in is synchronous; flag sources see a one-cycle event pulse
`timescale 1ns/1ns
module cssi_irq_arb
	import cssi_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic [NSRC-1:0]  src_in,
	input  wire logic [NSRC-1:0]  src_en,
	input  wire logic [NSRC-1:0]  w1c,
	input  wire logic             ack,
	input  wire logic [SRC_W-1:0] ack_idx,
	output logic      [NSRC-1:0]  pend,
	output logic                  req,
	output logic      [SRC_W-1:0] win_idx
);
	logic [NSRC-1:0] act;

	for (genvar i = 0; i < NSRC; i++) begin : g_src
		if (SRC_IS_LEVEL[i]) begin : g_lvl
			assign pend[i] = src_in[i];
		end else begin : g_flg
			logic flag;
			// a new event beats a clear in the same cycle
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag <= 1'b0;
				end else if (ce) begin
					flag <= src_in[i] | (flag & ~w1c[i] & ~(ack && ack_idx == SRC_W'(i)));
				end
			end
			assign pend[i] = flag;
		end
	end

	assign act = pend & src_en;
	assign req = |act;

	always_comb begin
		win_idx = '0;
		for (int j = NSRC - 1; j >= 0; j--) begin
			if (act[j]) begin
				win_idx = SRC_W'(j);
			end
		end
	end
endmodule

/* File: design/cssi_core.sv */
// cssi_core: status flags, stack pointer, pointer addressing and interrupt entry/exit
// assumes an outside sequencer presenting decoded ops on op_valid/op_ready, APB master
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module cssi_core
	import cssi_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        op_valid,
	output logic             op_ready,
	input  cssi_op_t         op_code,
	input  wire logic [4:0]  op_rd,
	input  wire logic [4:0]  op_rr,
	input  wire logic [2:0]  op_bit,
	input  wire logic [9:0]  op_imm,
	input  wire logic [1:0]  op_ptr,
	input  cssi_pmode_t      op_pmode,
	input  wire logic [NSRC-1:0] irq_src,
	output logic      [9:0]  pc,
	output logic      [7:0]  status,
	output logic             int_taken
);
	cssi_state_t      state_reg;
	logic [1:0]       step_reg;
	logic [7:0]       status_flags_reg;
	logic [7:0]       sp_reg;
	logic [9:0]       pc_reg;
	logic [9:0]       ret_reg;
	logic [9:0]       vec_reg;
	logic             interrupt_exit_instr_reg;
	logic             blk_reg;
	logic             taken_reg;
	logic [31:0]      prdata_reg;
	logic [NSRC-1:0]  ien_reg;
	logic [7:0]       sram [SRAM_WORDS];

	logic [7:0]       ra_data;
	logic [7:0]       rb_data;
	logic [4:0]       rb_addr;
	logic [3:0]       pr_sel;
	logic [15:0]      pr_data;
	logic             we8;
	logic [4:0]       wa;
	logic [7:0]       wd;
	logic             we16;
	logic [15:0]      wd16;
	logic [NSRC-1:0]  pend;
	logic             arb_req;
	logic [SRC_W-1:0] win_idx;
	logic [NSRC-1:0]  w1c;

	logic             idle;
	logic             take_int;
	logic             accept;
	logic             apb_wr;
	logic             hit;
	logic [31:0]      rd_mux;
	logic [15:0]      daddr;
	logic [15:0]      ptr_upd;
	logic             in_reg;
	logic             in_sram;
	logic [6:0]       didx;
	logic [6:0]       pidx;
	logic [6:0]       qidx;
	logic             sp_ok;
	logic             pop_ok;
	logic [7:0]       pop_byte;
	logic [7:0]       dread;
	logic             push_step;
	logic             pop_step;
	logic             step_done;
	logic             mem_we;
	logic [6:0]       mem_idx;
	logic [7:0]       mem_wd;
	logic [7:0]       a;
	logic [7:0]       b;
	logic [8:0]       sum9;
	logic [7:0]       res;
	logic [15:0]      res16;
	logic [7:0]       flags;
	logic             flag_upd;

	////////////////////////////////////////////////////////////////////////////////
	// sequencing and interrupt acceptance

	assign idle = (state_reg == ST_IDLE);
	// a mask op on the port blocks acceptance in its own cycle
	assign take_int = idle && ce && arb_req && status_flags_reg[BIT_I] && !blk_reg
		&& !(op_valid && op_code == OP_CLI);
	assign op_ready = idle && ce && !take_int;
	assign accept = op_valid && op_ready;
	assign push_step = (state_reg == ST_CALL || state_reg == ST_INT) && step_reg <= STK_LAST;
	assign pop_step = (state_reg == ST_RET) && step_reg <= STK_LAST;

	always_comb begin
		unique case (state_reg)
			ST_CALL: step_done = (step_reg == STK_LAST);
			ST_INT:  step_done = (step_reg == ENTRY_LAST);
			ST_RET:  step_done = (step_reg == RET_LAST);
			ST_IDLE: step_done = 1'b0;
		endcase
	end

	// single undivided core clock drives every state element
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			step_reg <= 2'h0;
		end else if (ce) begin
			if (take_int) begin
				state_reg <= ST_INT;
			end else if (accept && op_code == OP_CALL) begin
				state_reg <= ST_CALL;
			end else if (accept && (op_code == OP_RET || op_code == OP_INTERRUPT_EXIT_INSTR)) begin
				state_reg <= ST_RET;
			end else if (step_done) begin
				state_reg <= ST_IDLE;
				step_reg <= 2'h0;
			end else if (!idle) begin
				step_reg <= step_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= PC_RST;
			ret_reg <= PC_RST;
			vec_reg <= PC_RST;
			interrupt_exit_instr_reg <= 1'b0;
		end else if (ce) begin
			if (take_int) begin
				ret_reg <= pc_reg;
				vec_reg <= 10'(win_idx) + 10'h001;
			end else if (accept) begin
				if (op_code == OP_CALL) begin
					ret_reg <= pc_reg + 10'h001;
					pc_reg <= op_imm;
				end else begin
					pc_reg <= pc_reg + 10'h001;
				end
				interrupt_exit_instr_reg <= (op_code == OP_INTERRUPT_EXIT_INSTR);
			end
			if (pop_step && step_reg == 2'h0) begin
				ret_reg[9:8] <= pop_byte[1:0];
			end
			if (pop_step && step_reg == STK_LAST) begin
				ret_reg[7:0] <= pop_byte;
			end
			if (state_reg == ST_RET && step_done) begin
				pc_reg <= ret_reg;
			end
			if (state_reg == ST_INT && step_done) begin
				pc_reg <= vec_reg;
			end
		end
	end

	// after an exit or an unmask, one op must pass before the next entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_reg <= 1'b0;
			taken_reg <= 1'b0;
		end else if (ce) begin
			taken_reg <= take_int;
			if (accept) begin
				blk_reg <= (op_code == OP_SEI);
			end else if (state_reg == ST_RET && step_done && interrupt_exit_instr_reg) begin
				blk_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alu and flags

	always_comb begin
		a = ra_data;
		b = (op_code == OP_LDI) ? op_imm[7:0] : rb_data;
		sum9 = 9'h000;
		res = 8'h00;
		res16 = 16'h0000;
		flags = status_flags_reg;
		flag_upd = 1'b0;
		unique case (op_code)
			OP_ADD, OP_ADC: begin
				sum9 = {1'b0, a} + {1'b0, b}
					+ {8'h00, (op_code == OP_ADC) & status_flags_reg[BIT_C]};
				res = sum9[7:0];
				flags[BIT_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
				flags[BIT_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
				flags[BIT_C] = sum9[8];
				flag_upd = 1'b1;
			end
			OP_SUB: begin
				sum9 = {1'b0, a} - {1'b0, b};
				res = sum9[7:0];
				flags[BIT_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
				flags[BIT_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
				flags[BIT_C] = sum9[8];
				flag_upd = 1'b1;
			end
			OP_AND, OP_EOR: begin
				res = (op_code == OP_AND) ? (a & b) : (a ^ b);
				flags[BIT_V] = 1'b0;
				flag_upd = 1'b1;
			end
			OP_MOV, OP_LDI: res = b;
			OP_BLD: begin
				res = a;
				res[op_bit] = status_flags_reg[BIT_T];
			end
			OP_ADIW: begin
				res16 = pr_data + {10'h000, op_imm[5:0]};
				flags[BIT_V] = ~pr_data[15] & res16[15];
				flags[BIT_C] = pr_data[15] & ~res16[15];
				flag_upd = 1'b1;
			end
			default: begin
			end
		endcase
		if (flag_upd) begin
			flags[BIT_N] = (op_code == OP_ADIW) ? res16[15] : res[7];
			flags[BIT_Z] = (op_code == OP_ADIW) ? (res16 == 16'h0000) : (res == 8'h00);
			flags[BIT_S] = flags[BIT_N] ^ flags[BIT_V];
		end
	end

	// no push of the flags on entry and no restore on exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags_reg <= STATUS_RST;
		end else if (ce) begin
			if (apb_wr && paddr == ADDR_STATUS) begin
				status_flags_reg <= pwdata[7:0];
				status_flags_reg[BIT_S] <= pwdata[BIT_N] ^ pwdata[BIT_V];
			end
			if (accept) begin
				if (flag_upd) begin
					status_flags_reg[5:0] <= flags[5:0];
				end
				if (op_code == OP_BST) begin
					status_flags_reg[BIT_T] <= ra_data[op_bit];
				end
				if (op_code == OP_SEI || op_code == OP_CLI) begin
					status_flags_reg[BIT_I] <= (op_code == OP_SEI);
				end
			end
			if (take_int) begin
				status_flags_reg[BIT_I] <= 1'b0;
			end
			if (state_reg == ST_RET && step_done && interrupt_exit_instr_reg) begin
				status_flags_reg[BIT_I] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pointer addressing, data space and register file

	always_comb begin
		daddr = pr_data;
		ptr_upd = pr_data;
		unique case (op_pmode)
			PM_PLAIN: begin
			end
			PM_POSTINC: ptr_upd = pr_data + 16'h0001;
			PM_PREDEC: begin
				ptr_upd = pr_data - 16'h0001;
				daddr = ptr_upd;
			end
			PM_DISP: daddr = pr_data + {10'h000, op_imm[5:0]};
		endcase
	end

	assign pr_sel = (op_code == OP_ADIW) ? PAIR_W + {2'b00, op_rd[1:0]} : PAIR_X + {2'b00, op_ptr};
	assign in_reg = (daddr < REG_SPACE_END);
	assign in_sram = (daddr >= SRAM_BASE) && (daddr < SRAM_END);
	assign didx = 7'(daddr - SRAM_BASE);
	assign rb_addr = (op_code == OP_LD) ? daddr[4:0] : op_rr;
	assign dread = in_reg ? rb_data : (in_sram ? sram[didx] : 8'h00);

	// stack outside the memory window is dropped: software keeps it above 0x60
	assign sp_ok = ({8'h00, sp_reg} >= SRAM_BASE) && ({8'h00, sp_reg} < SRAM_END);
	assign pop_ok = ({8'h00, sp_reg} + 16'h0001 >= SRAM_BASE)
		&& ({8'h00, sp_reg} + 16'h0001 < SRAM_END);
	assign pidx = 7'(sp_reg - SRAM_BASE[7:0]);
	assign qidx = 7'(sp_reg + 8'h01 - SRAM_BASE[7:0]);
	assign pop_byte = pop_ok ? sram[qidx] : 8'h00;

	always_comb begin
		we8 = accept && (op_code inside {OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_EOR, OP_MOV,
			OP_LDI, OP_BLD, OP_POP, OP_LD} || (op_code == OP_ST && in_reg));
		wa = (op_code == OP_ST) ? daddr[4:0] : op_rd;
		unique case (op_code)
			OP_ST:   wd = ra_data;
			OP_POP:  wd = pop_byte;
			OP_LD:   wd = dread;
			default: wd = res;
		endcase
		we16 = accept && (op_code == OP_ADIW || ((op_code == OP_LD || op_code == OP_ST)
			&& (op_pmode == PM_POSTINC || op_pmode == PM_PREDEC)));
		wd16 = (op_code == OP_ADIW) ? res16 : ptr_upd;
	end

	cssi_regfile u_regfile (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.ra_addr (op_rd),
		.ra_data (ra_data),
		.rb_addr (rb_addr),
		.rb_data (rb_data),
		.pr_sel  (pr_sel),
		.pr_data (pr_data),
		.we8     (we8),
		.wa      (wa),
		.wd      (wd),
		.we16    (we16),
		.wpair   (pr_sel),
		.wd16    (wd16)
	);

	////////////////////////////////////////////////////////////////////////////////
	// stack and data memory

	always_comb begin
		mem_we = 1'b0;
		mem_idx = pidx;
		mem_wd = ra_data;
		if (accept && op_code == OP_PUSH) begin
			mem_we = sp_ok;
		end else if (accept && op_code == OP_ST) begin
			mem_we = in_sram;
			mem_idx = didx;
		end else if (push_step) begin
			mem_we = sp_ok;
			mem_wd = (step_reg == 2'h0) ? ret_reg[7:0] : {6'h00, ret_reg[9:8]};
		end
	end

	always_ff @(posedge pclk) begin
		if (ce && mem_we) begin
			sram[mem_idx] <= mem_wd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_reg <= SP_RST;
		end else if (ce) begin
			if (apb_wr && paddr == ADDR_SPL) begin
				sp_reg <= pwdata[7:0];
			end
			if (accept && op_code == OP_PUSH) begin
				sp_reg <= sp_reg - 8'h01;
			end
			if (accept && op_code == OP_POP) begin
				sp_reg <= sp_reg + 8'h01;
			end
			if (push_step) begin
				sp_reg <= sp_reg - 8'h01;
			end
			if (pop_step) begin
				sp_reg <= sp_reg + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt sources

	assign w1c = (apb_wr && paddr == ADDR_IFLG) ? pwdata[NSRC-1:0] : '0;

	cssi_irq_arb u_arb (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.src_in  (irq_src),
		.src_en  (ien_reg),
		.w1c     (w1c),
		.ack     (take_int),
		.ack_idx (win_idx),
		.pend    (pend),
		.req     (arb_req),
		.win_idx (win_idx)
	);

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait, read data captured in the setup cycle

	assign apb_wr = psel && penable && pwrite && ce;
	assign pready = ce;
	assign pslverr = psel && penable && !hit;

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			ADDR_STATUS: rd_mux[7:0] = status_flags_reg;
			ADDR_SPL:    rd_mux[7:0] = sp_reg;
			ADDR_SPH:    rd_mux = 32'h0000_0000;
			ADDR_IEN:    rd_mux[NSRC-1:0] = ien_reg;
			ADDR_IFLG:   rd_mux[NSRC-1:0] = pend;
			ADDR_PC:     rd_mux[9:0] = pc_reg;
			default:     hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			ien_reg <= '0;
		end else if (ce) begin
			if (psel && !penable) begin
				prdata_reg <= rd_mux;
			end
			if (apb_wr && paddr == ADDR_IEN) begin
				ien_reg <= pwdata[NSRC-1:0];
			end
		end
	end

	assign prdata = prdata_reg;
	assign pc = pc_reg;
	assign status = status_flags_reg;
	assign int_taken = taken_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_no_int_wo_gie;
		(ce && !status_flags_reg[BIT_I]) |=> !int_taken;
	endproperty
	a_no_int_wo_gie: assert property (p_no_int_wo_gie) else $error("entry with enable clear");

	property p_gie_cleared;
		$rose(int_taken) |-> !status_flags_reg[BIT_I] && state_reg == ST_INT;
	endproperty
	a_gie_cleared: assert property (p_gie_cleared) else $error("enable kept on entry");

	property p_cli_wins;
		(accept && op_code == OP_CLI) |=> !int_taken && !status_flags_reg[BIT_I];
	endproperty
	a_cli_wins: assert property (p_cli_wins) else $error("entry beside mask op");

	property p_push_sp;
		(accept && op_code == OP_PUSH && !apb_wr) |=> sp_reg == $past(sp_reg) - 8'h01;
	endproperty
	a_push_sp: assert property (p_push_sp) else $error("push moved sp wrongly");

	property p_call_sp;
		(accept && op_code == OP_CALL && !apb_wr) ##1 (ce && !apb_wr) [*2]
			|=> sp_reg == $past(sp_reg, 3) - 8'h02;
	endproperty
	a_call_sp: assert property (p_call_sp) else $error("call moved sp wrongly");

	property p_entry_len;
		take_int |=> !op_ready [*4];
	endproperty
	a_entry_len: assert property (p_entry_len) else $error("entry shorter than four");

	property p_interrupt_exit_instr_len;
		(accept && op_code == OP_INTERRUPT_EXIT_INSTR) ##1 ce [*3] |=> status_flags_reg[BIT_I] && blk_reg && idle;
	endproperty
	a_interrupt_exit_instr_len: assert property (p_interrupt_exit_instr_len) else $error("exit not done in four");

	property p_one_op_after;
		(ce && blk_reg && !accept) |=> !int_taken;
	endproperty
	a_one_op_after: assert property (p_one_op_after) else $error("entry before one op");

	property p_vector;
		$rose(int_taken) ##0 ce [*4] |=> pc_reg == $past(vec_reg) && idle;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector after entry");
endmodule

/* File: tb/tb.sv */
// tb: self-checking bench for cssi_core, random ALU data plus corner cases
// assumes cssi_pkg is compiled first and the core answers APB with no wait
`timescale 1ns/1ns
module tb;
	import cssi_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, op_valid = 0;
	logic [7:0]  paddr = '0, a, b, s;
	logic [31:0] pwdata = '0, r, prdata;
	logic        pready, pslverr, op_ready, int_taken, perr;
	logic [4:0]  op_rd = '0, op_rr = 5'h11;
	logic [2:0]  op_bit = '0;
	logic [9:0]  op_imm = '0, pc;
	logic [3:0]  irq_src = '0;
	logic [7:0]  status;
	cssi_op_t    op_code = OP_NOP;
	logic [1:0]  op_ptr = '0;
	cssi_pmode_t op_pmode = PM_PLAIN;
	int          error_cnt = 0, total_checks = 0, seed = 32'h2945, nint = 0;

	cssi_core cssi_core_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready),
		.op_code(op_code), .op_rd(op_rd), .op_rr(op_rr), .op_bit(op_bit), .op_imm(op_imm),
		.op_ptr(op_ptr), .op_pmode(op_pmode), .irq_src(irq_src), .pc(pc), .status(status),
		.int_taken(int_taken));

	always #20 pclk = ~pclk;
	always @(posedge pclk) if (int_taken === 1'b1) nint <= nint + 1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang;
		error_cnt++;
		$display("Error %0t: no answer", $time);
		summarize();
	endtask
	// op_ready is combinational, so look at it mid-cycle, not on the edge
	task automatic rdy;
		int n;
		n = 0;
		do @(negedge pclk); while (op_ready !== 1'b1 && ++n < 50);
		if (n >= 50) hang();
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50) hang();
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic op(input cssi_op_t c, input logic [4:0] d, input logic [9:0] i);
		op_valid <= 1'b1;
		op_code <= c;
		op_rd <= d;
		op_imm <= i;
		rdy();
		@(posedge pclk);
		op_valid <= 1'b0;
		rdy();
		@(posedge pclk);
	endtask
	function automatic logic [7:0] addf(input logic [7:0] x, y);
		logic [8:0] t;
		logic       v;
		t = x + y;
		v = (x[7] == y[7]) && (t[7] != x[7]);
		return {2'h0, ({1'b0, x[3:0]} + y[3:0]) > 5'h0F, t[7] ^ v, v, t[7], t[7:0] == 8'h00, t[8]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 3; k++) begin
			apb(1'b0, 8'(4 * k), '0);
			chk(r, '0);
		end
		apb(1'b1, ADDR_SPL, 32'hDF);
		apb(1'b1, ADDR_SPH, 32'h55);
		apb(1'b0, ADDR_SPH, '0);
		chk(r, '0);
		apb(1'b0, 8'h40, '0);
		chk(perr, 1'b1);
		// first two pairs force overflow and a zero result with carry
		for (int k = 0; k < 10; k++) begin
			a = k == 0 ? 8'h7F : k == 1 ? 8'h80 : 8'($random(seed));
			b = k == 0 ? 8'h01 : k == 1 ? 8'h80 : 8'($random(seed));
			op(OP_LDI, 5'h10, {2'h0, a});
			op(OP_LDI, 5'h11, {2'h0, b});
			op(OP_ADD, 5'h10, '0);
			apb(1'b0, ADDR_STATUS, '0);
			chk(r, addf(a, b));
			op(OP_ADD, 5'h10, '0);
			apb(1'b0, ADDR_STATUS, '0);
			chk(r, addf(a + b, b));
		end
		s = 8'($random(seed)) & 8'h7F;
		apb(1'b1, ADDR_STATUS, s);
		apb(1'b0, ADDR_STATUS, '0);
		chk(r, {s[7:5], s[3] ^ s[2], s[3:0]});
		a = 8'($random(seed));
		op(OP_LDI, 5'h14, {2'h0, a});
		for (int k = 0; k < 8; k++) begin
			op_bit <= 3'(k);
			op(OP_BST, 5'h14, '0);
			chk(status[6], a[k]);
		end
		apb(1'b1, ADDR_STATUS, '0);
		op(OP_PUSH, 5'h10, '0);
		apb(1'b0, ADDR_SPL, '0);
		chk(r, 32'hDE);
		op(OP_POP, 5'h11, '0);
		apb(1'b0, ADDR_SPL, '0);
		chk(r, 32'hDF);
		op(OP_CALL, '0, 10'h123);
		chk(pc, 10'h123);
		apb(1'b0, ADDR_SPL, '0);
		chk(r, 32'hDD);
		op(OP_RET, '0, '0);
		apb(1'b0, ADDR_SPL, '0);
		chk(r, 32'hDF);
		// store through X into r5 post-increment, load it back pre-decrement
		op_pmode <= PM_POSTINC;
		op(OP_LDI, 5'h10, 10'h03C);
		op(OP_LDI, 5'h1A, 10'h005);
		op(OP_LDI, 5'h1B, 10'h000);
		op(OP_ST, 5'h10, '0);
		op_pmode <= PM_PREDEC;
		op(OP_LD, 5'h11, '0);
		op_pmode <= PM_PLAIN;
		op(OP_ADD, 5'h10, '0);
		apb(1'b0, ADDR_STATUS, '0);
		chk(r, addf(8'h3C, 8'h3C));
		// two flag sources pend while globally masked
		apb(1'b1, ADDR_IEN, 32'h7);
		irq_src <= 4'h3;
		@(posedge pclk);
		irq_src <= 4'h0;
		repeat (4) @(posedge pclk);
		apb(1'b0, ADDR_IFLG, '0);
		chk(r, 32'h3);
		chk(nint, 0);
		op(OP_SEI, '0, '0);
		chk(nint, 0);
		op(OP_NOP, '0, '0);
		chk(pc, 10'h001);
		chk(status[7], 1'b0);
		apb(1'b0, ADDR_SPL, '0);
		chk(r, 32'hDD);
		apb(1'b0, ADDR_IFLG, '0);
		chk(r, 32'h2);
		op(OP_INTERRUPT_EXIT_INSTR, '0, '0);
		chk(status[7], 1'b1);
		chk(nint, 1);
		op(OP_NOP, '0, '0);
		chk(pc, 10'h002);
		op(OP_INTERRUPT_EXIT_INSTR, '0, '0);
		irq_src <= 4'h4;
		op(OP_CLI, '0, '0);
		irq_src <= 4'h0;
		chk(nint, 2);
		chk(status[7], 1'b0);
		apb(1'b0, ADDR_IFLG, '0);
		chk(r, 32'h4);
		apb(1'b1, ADDR_IFLG, 32'h4);
		apb(1'b0, ADDR_IFLG, '0);
		chk(r, '0);
		// level source gone before enable must not fire
		apb(1'b1, ADDR_IEN, 32'h8);
		irq_src <= 4'h8;
		repeat (3) @(posedge pclk);
		irq_src <= 4'h0;
		@(posedge pclk);
		op(OP_SEI, '0, '0);
		op(OP_NOP, '0, '0);
		chk(nint, 2);
		irq_src <= 4'h8;
		op(OP_NOP, '0, '0);
		chk(pc, 10'h005);
		summarize();
	end
endmodule
